// ### verilog/fsp_poll_host.sv
// fsp_poll_host: host-side controller polling a parallel flash for write status
// assumes software issues command cycles first, then starts a poll at the target
// What this block does
// - data poll reads use the programmed address.
// - erase polls read an address inside a sector being erased.
// - after bit 7 turns true, valid data comes from a later read.
// - re-read bit 7 after the timeout bit reads one.
// - start toggle polling with two reads; equal means done.
// - toggling with timeout high: recheck, still toggling means fail, reset.
// - an interrupted toggle poll restarts from its first double read.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fsp_poll_host #(
  parameter int AW = 18,
  parameter int DW = 16
) (
  input  wire logic          I_REF_CLK,
  input  wire logic          I_SYS_RST,
  input  wire logic          I_CLK_EN,
  input  wire logic [4:0]    I_AVS_ADDRESS,
  input  wire logic          I_AVS_READ,
  input  wire logic          I_AVS_WRITE,
  input  wire logic [31:0]   I_AVS_WRITEDATA,
  input  wire logic [3:0]    I_AVS_BYTEENABLE,
  output logic [31:0]        O_AVS_READDATA,
  output logic               O_AVS_WAITREQUEST,
  output logic               O_FL_CE_N,
  output logic               O_FL_OE_N,
  output logic               O_FL_WE_N,
  output logic [AW-1:0]      O_FL_ADDR,
  output logic [DW-1:0]      O_FL_DQ,
  output logic               O_FL_DQ_OE,
  input  wire logic [DW-1:0] I_FL_DQ,
  input  wire logic          I_FL_READY_BUSY
);
  fsp_cyc_if #(.AW(AW), .DW(DW)) cyc ();

  fsp_pkg::fsp_state_t st;
  fsp_pkg::fsp_state_t next_st;
  fsp_pkg::fsp_op_t    op_q;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] data_reg;
  logic [DW-1:0] last_rd;
  logic          issued;
  logic          done_f;
  logic          fail_f;
  logic          susp_f;
  logic          abort_q;
  logic          first_gtog;
  logic          first_stog;
  logic          ack;
  logic          ryby_meta;
  logic          ryby_s;

  // -----------------------------------------------------------
  // bus slave decode
  // -----------------------------------------------------------
  wire        acc      = I_AVS_READ | I_AVS_WRITE;
  wire        take     = acc & ack & I_CLK_EN;
  wire        wr_take  = take & I_AVS_WRITE;
  wire        sel_ctrl = (I_AVS_ADDRESS == fsp_pkg::OFS_CTRL);
  wire        sel_addr = (I_AVS_ADDRESS == fsp_pkg::OFS_ADDR);
  wire        sel_data = (I_AVS_ADDRESS == fsp_pkg::OFS_DATA);
  wire        sel_stat = (I_AVS_ADDRESS == fsp_pkg::OFS_STAT);
  wire [31:0] be_mask  = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
                          {8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
  wire [31:0] addr_mrg = (32'(addr_reg) & ~be_mask) | (I_AVS_WRITEDATA & be_mask);
  wire [31:0] data_mrg = (32'(data_reg) & ~be_mask) | (I_AVS_WRITEDATA & be_mask);
  wire [2:0]  op_wd    = I_AVS_WRITEDATA[2:0];
  wire        op_ok    = (op_wd >= 3'(fsp_pkg::OP_WRITE)) &&
                         (op_wd <= 3'(fsp_pkg::OP_TPOLL));
  wire        busy     = (st != fsp_pkg::S_IDLE);
  // a start while busy is ignored; the running operation keeps its mode
  wire        start    = wr_take & sel_ctrl & I_AVS_BYTEENABLE[0] & op_ok & ~busy;
  wire        abort_wr = wr_take & sel_ctrl & I_AVS_BYTEENABLE[0] &
                         I_AVS_WRITEDATA[fsp_pkg::CTRL_ABORT];
  wire [4:0]  flags    = {susp_f, ryby_s, fail_f, done_f, busy};
  wire [31:0] stat_wd  = 32'(last_rd) | (32'(flags) << fsp_pkg::ST_LSB);
  wire [31:0] rd_mux   = sel_ctrl ? 32'(op_q) :
                         sel_addr ? 32'(addr_reg) :
                         sel_data ? 32'(data_reg) :
                         sel_stat ? stat_wd : 32'h0000_0000;

  // one wait state per access; a frozen clock keeps the request waiting
  assign O_AVS_WAITREQUEST = acc & ~(ack & I_CLK_EN);

  // -----------------------------------------------------------
  // bus slave timing
  // -----------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SYS_RST)
    begin
      ack <= 1'b0;
      O_AVS_READDATA <= 32'h0000_0000;
    end
    else if (I_CLK_EN)
    begin
      ack <= acc & ~ack;
      O_AVS_READDATA <= rd_mux;  // unmapped offsets read zero
    end
  end

  // -----------------------------------------------------------
  // software registers
  // -----------------------------------------------------------
  // the poll address must be the program address or an erasing sector
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SYS_RST)
    begin
      addr_reg <= '0;
      data_reg <= '0;
      op_q <= fsp_pkg::OP_NONE;
    end
    else if (I_CLK_EN)
    begin
      if (wr_take && sel_addr && !busy)
        addr_reg <= addr_mrg[AW-1:0];
      if (wr_take && sel_data && !busy)
        data_reg <= data_mrg[DW-1:0];
      if (start)
        op_q <= fsp_pkg::fsp_op_t'(op_wd);
    end
  end

  // -----------------------------------------------------------
  // ready/busy pin synchroniser
  // -----------------------------------------------------------
  // the wired line reads high when released and low while busy
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_CLK_EN)
    begin
      ryby_meta <= I_FL_READY_BUSY;
      ryby_s <= ryby_meta;
    end
  end

  // -----------------------------------------------------------
  // status decode of the last read
  // -----------------------------------------------------------
  wire [DW-1:0] rd       = cyc.rdata;
  wire          exp_poll = data_reg[fsp_pkg::COMPLETION_POLL_BIT];
  wire          poll_ok  = (rd[fsp_pkg::COMPLETION_POLL_BIT] == exp_poll);
  wire          tout     = rd[fsp_pkg::TIMEOUT_FAIL_BIT];
  wire          gtog_eq  = (rd[fsp_pkg::GLOBAL_TOGGLE_BIT] == first_gtog);
  wire          stog_chg = (rd[fsp_pkg::SECTOR_TOGGLE_BIT] != first_stog);
  wire          dmode    = (op_q == fsp_pkg::OP_DPOLL);

  // -----------------------------------------------------------
  // poll sequence, next state on each completed read
  // -----------------------------------------------------------
  always_comb
  begin
    next_st = fsp_pkg::S_IDLE;
    case (st)
      fsp_pkg::S_RD_A:
        if (!dmode)
          next_st = fsp_pkg::S_RD_B;
        else if (poll_ok)
          next_st = fsp_pkg::S_FINAL;
        else if (tout)
          next_st = fsp_pkg::S_CHK_A;
        else
          next_st = fsp_pkg::S_RD_A;
      fsp_pkg::S_RD_B:
        if (gtog_eq)
          next_st = fsp_pkg::S_FINAL;
        else if (tout)
          next_st = fsp_pkg::S_CHK_A;
        else
          next_st = fsp_pkg::S_RD_A;
      fsp_pkg::S_CHK_A:
        if (!dmode)
          next_st = fsp_pkg::S_CHK_B;
        else if (poll_ok)
          next_st = fsp_pkg::S_FINAL;
        else
          next_st = fsp_pkg::S_RST;
      fsp_pkg::S_CHK_B:
        next_st = gtog_eq ? fsp_pkg::S_FINAL : fsp_pkg::S_RST;
      default:
        next_st = fsp_pkg::S_IDLE;
    endcase
    if (abort_q)
      next_st = fsp_pkg::S_IDLE;
  end

  // first state of each operation; every poll starts from its first read
  wire fsp_pkg::fsp_state_t start_st =
    (op_wd == 3'(fsp_pkg::OP_WRITE)) ? fsp_pkg::S_WR :
    (op_wd == 3'(fsp_pkg::OP_READ))  ? fsp_pkg::S_RD : fsp_pkg::S_RD_A;

  // -----------------------------------------------------------
  // cycle requests to the engine
  // -----------------------------------------------------------
  // the engine finishes every write before a poll can start
  wire is_rst = (st == fsp_pkg::S_RST);
  assign cyc.req   = busy & ~issued & cyc.ready;
  assign cyc.wr    = (st == fsp_pkg::S_WR) | is_rst;
  assign cyc.addr  = addr_reg;
  assign cyc.wdata = is_rst ? DW'(fsp_pkg::RESET_CMD) : data_reg;

  // -----------------------------------------------------------
  // sequencer state
  // -----------------------------------------------------------
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SYS_RST)
    begin
      st <= fsp_pkg::S_IDLE;
      issued <= 1'b0;
      last_rd <= '0;
      first_gtog <= 1'b0;
      first_stog <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      if (start)
      begin
        st <= start_st;
        issued <= 1'b0;
      end
      else if (cyc.done)
      begin
        st <= next_st;
        issued <= 1'b0;
        last_rd <= rd;
        if (st == fsp_pkg::S_RD_A || st == fsp_pkg::S_CHK_A)
        begin
          first_gtog <= rd[fsp_pkg::GLOBAL_TOGGLE_BIT];
          first_stog <= rd[fsp_pkg::SECTOR_TOGGLE_BIT];
        end
      end
      else if (cyc.req)
        issued <= 1'b1;
    end
  end

  // -----------------------------------------------------------
  // result flags
  // -----------------------------------------------------------
  // flags clear only at the next start, so a finished result is never lost
  wire fin      = cyc.done & busy & (next_st == fsp_pkg::S_IDLE);
  wire to_fail  = cyc.done & (next_st == fsp_pkg::S_RST);
  wire susp_set = cyc.done & (st == fsp_pkg::S_RD_B) & gtog_eq & stog_chg;
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_SYS_RST)
    begin
      done_f <= 1'b0;
      fail_f <= 1'b0;
      susp_f <= 1'b0;
      abort_q <= 1'b0;
    end
    else if (I_CLK_EN)
    begin
      done_f <= ~start & (done_f | fin);
      fail_f <= ~start & (fail_f | to_fail);
      susp_f <= ~start & (susp_f | susp_set);
      // an abort is held until the cycle in flight completes
      abort_q <= (abort_wr & busy) | (abort_q & busy & ~start);
    end
  end

  // -----------------------------------------------------------
  // flash cycle engine
  // -----------------------------------------------------------
  fsp_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_ce    (I_CLK_EN),
    .cyc     (cyc),
    .o_ce_n  (O_FL_CE_N),
    .o_oe_n  (O_FL_OE_N),
    .o_we_n  (O_FL_WE_N),
    .o_addr  (O_FL_ADDR),
    .o_dq    (O_FL_DQ),
    .o_dq_oe (O_FL_DQ_OE),
    .i_dq    (I_FL_DQ)
  );
endmodule
`default_nettype wire

// ### verilog/fsp_pkg.sv
// fsp_pkg: constants, field layouts and state types of the flash status poller
// assumes a 125 MHz reference clock and a parallel flash with x8/x16 data
`default_nettype none
package fsp_pkg;
  // -----------------------------------------------------------
  // timing of one flash bus cycle
  // -----------------------------------------------------------
  localparam int CLK_NS  = 8;
  localparam int RD_NS   = 100;  // output enable low to data valid
  localparam int WR_NS   = 50;   // write strobe low width
  localparam int GAP_NS  = 30;   // strobes high between two cycles
  localparam int SYNC_CYC = 2;   // data pins pass two flip-flops
  localparam int RD_CYC  = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC  = (WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RD_CNT  = 8'(RD_CYC + SYNC_CYC - 1);
  localparam logic [7:0] WR_CNT  = 8'(WR_CYC - 1);
  localparam logic [7:0] GAP_CNT = 8'(GAP_CYC - 1);
  // -----------------------------------------------------------
  // register map, byte addresses
  // -----------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0c;
  localparam int CTRL_ABORT = 3;
  localparam int ST_LSB     = 16;  // busy, done, fail, ready, suspended
  // -----------------------------------------------------------
  // status bit positions on the flash data bus
  // -----------------------------------------------------------
  localparam int COMPLETION_POLL_BIT = 7;
  localparam int GLOBAL_TOGGLE_BIT   = 6;
  localparam int TIMEOUT_FAIL_BIT    = 5;
  localparam int SECTOR_TOGGLE_BIT   = 2;
  localparam logic [7:0] RESET_CMD  = 8'hf0;
  // -----------------------------------------------------------
  // types
  // -----------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_WRITE = 3'h1, OP_READ = 3'h2,
    OP_DPOLL = 3'h3, OP_TPOLL = 3'h4
  } fsp_op_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RD_A = 4'h1, S_RD_B = 4'h3, S_CHK_A = 4'h2,
    S_CHK_B = 4'h6, S_FINAL = 4'h7, S_RST = 4'h5, S_WR = 4'h4,
    S_RD = 4'hc
  } fsp_state_t;
  typedef enum logic [1:0] {
    E_IDLE = 2'b00, E_ACT = 2'b01, E_HOLD = 2'b11, E_GAP = 2'b10
  } fsp_eng_t;
endpackage
`default_nettype wire

// ### verilog/fsp_cyc_if.sv
// fsp_cyc_if: one flash bus cycle request between sequencer and engine
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface fsp_cyc_if #(parameter int AW = 18, parameter int DW = 16);
  logic          req;
  logic          wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic          ready;
  logic          done;
  modport ctl (output req, wr, addr, wdata, input rdata, ready, done);
  modport eng (input req, wr, addr, wdata, output rdata, ready, done);
endinterface
`default_nettype wire

// ### verilog/fsp_cycle.sv
// fsp_cycle: runs one asynchronous read or write cycle on the flash pins
// assumes requests come only while ready is high; data pins pass a two-flop synchroniser
`timescale 1ns/100ps
`default_nettype none
module fsp_cycle #(
  parameter int AW = 18,
  parameter int DW = 16
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_ce,
  fsp_cyc_if.eng             cyc,
  output logic               o_ce_n,
  output logic               o_oe_n,
  output logic               o_we_n,
  output logic [AW-1:0]      o_addr,
  output logic [DW-1:0]      o_dq,
  output logic               o_dq_oe,
  input  wire logic [DW-1:0] i_dq
);
  fsp_pkg::fsp_eng_t st;
  logic [7:0]        cnt;
  logic              wr_q;
  logic [DW-1:0]     dq_meta;
  logic [DW-1:0]     dq_sync;
  logic [DW-1:0]     rdata;
  logic              done;
  wire               cnt_end = (cnt == 8'h00);

  // -----------------------------------------------------------
  // pin input synchroniser
  // -----------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_ce)
    begin
      dq_meta <= i_dq;
      dq_sync <= dq_meta;
    end
  end

  assign cyc.ready = (st == fsp_pkg::E_IDLE);
  assign cyc.rdata = rdata;
  assign cyc.done  = done;

  // -----------------------------------------------------------
  // cycle sequencer
  // -----------------------------------------------------------
  // strobes go high between cycles so each status read is a fresh cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st <= fsp_pkg::E_IDLE;
      cnt <= 8'h00;
      wr_q <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_addr <= '0;
      o_dq <= '0;
      o_dq_oe <= 1'b0;
    end
    else if (i_ce)
    begin
      done <= 1'b0;
      case (st)
        fsp_pkg::E_IDLE:
          if (cyc.req)
          begin
            o_addr <= cyc.addr;
            o_ce_n <= 1'b0;
            wr_q <= cyc.wr;
            o_we_n <= ~cyc.wr;
            o_oe_n <= cyc.wr;
            o_dq <= cyc.wdata;
            o_dq_oe <= cyc.wr;
            cnt <= cyc.wr ? fsp_pkg::WR_CNT : fsp_pkg::RD_CNT;
            st <= fsp_pkg::E_ACT;
          end
        fsp_pkg::E_ACT:
          if (cnt_end)
          begin
            o_we_n <= 1'b1;  // rising edge latches the write data
            o_oe_n <= 1'b1;
            if (!wr_q)
              rdata <= dq_sync;  // sampled before output enable rises
            st <= fsp_pkg::E_HOLD;
          end
          else
            cnt <= cnt - 8'h01;
        fsp_pkg::E_HOLD:
        begin
          o_ce_n <= 1'b1;
          o_dq_oe <= 1'b0;  // data held one cycle past the write edge
          cnt <= fsp_pkg::GAP_CNT;
          st <= fsp_pkg::E_GAP;
        end
        fsp_pkg::E_GAP:
          if (cnt_end)
          begin
            done <= 1'b1;
            st <= fsp_pkg::E_IDLE;
          end
          else
            cnt <= cnt - 8'h01;
        default:
          st <= fsp_pkg::E_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/fsp_flash_model.sv
// fsp_flash_model: behavioural flash that answers status reads
// assumes host strobes and a status set-up given by the bench
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model (
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [17:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_mode,
  input  wire logic [7:0]  i_busy_n,
  input  wire logic        i_pd7,
  input  wire logic [15:0] i_array,
  input  wire logic        i_dq_oe,
  output logic [15:0]      o_dq,
  output logic             o_rb_low
);
  int          reads = 0;
  logic        t6 = 1'b0;
  logic        t2 = 1'b0;
  logic        in_rd = 1'b0;
  logic        rst_seen = 1'b0;
  logic [17:0] rd_addr;
  logic [17:0] wr_addr;
  logic [15:0] wr_data;
  logic [15:0] last = 16'h0000;
  logic [15:0] stat;
  logic        active;
  logic        prog;
  // mode 0 program, 1 erase, 2 failing program, 3 erase suspend
  assign prog = (i_mode == 2'h0) || (i_mode == 2'h2);
  // a failing program stays busy until the reset command
  assign active = (i_mode == 2'h2) ? !rst_seen
                : (i_mode != 2'h3) && (reads < int'(i_busy_n));
  // address ignored: toggle status reads the same anywhere
  assign stat = (!active && i_mode != 2'h3) ? i_array
              : {8'h00, prog ? ~i_pd7 : (i_mode == 2'h3), t6,
                 (i_mode == 2'h2) && (reads >= int'(i_busy_n)), 2'h0, t2, 2'h0};
  // released bus shows the inverse, never a stale value
  assign o_dq = (!i_ce_n && !i_oe_n && !i_dq_oe) ? stat : ~last;
  assign o_rb_low = active;
  // status restarts at each rising edge of the bench go pulse
  always @(posedge i_go)
  begin
    reads = 0;
    rst_seen = 1'b0;
  end
  // a read cycle completes when either strobe goes high
  always @(i_ce_n or i_oe_n)
    if (!i_ce_n && !i_oe_n)
    begin
      in_rd = 1'b1;
      rd_addr = i_addr;
    end
    else if (in_rd)
    begin
      in_rd = 1'b0;
      last = stat;
      if (active) t6 = ~t6;
      if ((active && i_mode == 2'h1) || i_mode == 2'h3) t2 = ~t2;
      reads = reads + 1;
    end
  // write data latch on the rising write strobe
  always @(posedge i_we_n)
    if (!i_ce_n)
    begin
      wr_addr = i_addr;
      wr_data = i_dq;
      if (i_dq[7:0] == 8'hf0) rst_seen = 1'b1;
    end
endmodule
`default_nettype wire

// ### tb/fsp_poll_host_chk.sv
// fsp_poll_host_chk: strobe and bus timing checks on the poller
// assumes one clock with the clock enable held high
`timescale 1ns/100ps
`default_nettype none
module fsp_poll_host_chk #(
  parameter int AW = 18,
  parameter int DW = 16
) (
  input wire logic          I_REF_CLK,
  input wire logic          I_SYS_RST,
  input wire logic          I_AVS_READ,
  input wire logic          I_AVS_WRITE,
  input wire logic          O_AVS_WAITREQUEST,
  input wire logic          O_FL_CE_N,
  input wire logic          O_FL_OE_N,
  input wire logic          O_FL_WE_N,
  input wire logic [DW-1:0] O_FL_DQ,
  input wire logic          O_FL_DQ_OE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  // pin and bus timing
  idle_reset_a: assert property ($fell(I_SYS_RST) |->
    O_FL_CE_N && O_FL_OE_N && O_FL_WE_N && !O_FL_DQ_OE) else $error("strobes not idle");
  no_rdwr_a: assert property (O_FL_OE_N || O_FL_WE_N) else $error("read and write strobes");
  no_fight_a: assert property (O_FL_DQ_OE |-> O_FL_OE_N && !O_FL_CE_N)
    else $error("data driven outside write");
  read_len_a: assert property ($fell(O_FL_OE_N) |->
    !O_FL_CE_N ##14 !O_FL_OE_N ##1 O_FL_OE_N) else $error("read length");
  write_len_a: assert property ($fell(O_FL_WE_N) |->
    ##7 O_FL_WE_N && !O_FL_CE_N ##1 O_FL_CE_N && !O_FL_DQ_OE) else $error("write length");
  data_hold_a: assert property ($rose(O_FL_WE_N) |-> $stable(O_FL_DQ) && O_FL_DQ_OE)
    else $error("data moved at write end");
  gap_len_a: assert property ($rose(O_FL_CE_N) |-> O_FL_CE_N [*4])
    else $error("gap too short");
  one_wait_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST
    |=> !O_AVS_WAITREQUEST) else $error("bus answer late");
endmodule
bind fsp_poll_host fsp_poll_host_chk #(.AW(AW), .DW(DW)) i_chk (.I_REF_CLK, .I_SYS_RST,
  .I_AVS_READ, .I_AVS_WRITE, .O_AVS_WAITREQUEST, .O_FL_CE_N, .O_FL_OE_N, .O_FL_WE_N,
  .O_FL_DQ, .O_FL_DQ_OE);
`default_nettype wire

// ### tb/fsp_poll_host_test.sv
// fsp_poll_host_test: poller against a behavioural flash
// assumes the clock enable and byte enables stay high
`timescale 1ns/100ps
`default_nettype none
module fsp_poll_host_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [4:0]  av_a = 5'h00;
  logic [31:0] av_d = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic        ce_n, oe_n, we_n, dq_oe, rb_low;
  logic [17:0] fl_a;
  logic [15:0] fl_dq, mdq, dq_w;
  logic        go = 1'b0;
  logic        pd7 = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  busy = 8'h00;
  logic [15:0] arr = 16'h0000;
  int          fails = 0;
  int          num_checks = 0;
  // one wire level from both drivers
  assign dq_w = dq_oe ? fl_dq : mdq;
  always #4 clk = ~clk;
  fsp_poll_host i_dut (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(1'b1),
    .I_AVS_ADDRESS(av_a), .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_d),
    .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
    .O_FL_CE_N(ce_n), .O_FL_OE_N(oe_n), .O_FL_WE_N(we_n), .O_FL_ADDR(fl_a),
    .O_FL_DQ(fl_dq), .O_FL_DQ_OE(dq_oe), .I_FL_DQ(dq_w), .I_FL_READY_BUSY(!rb_low));
  fsp_flash_model i_fm (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(fl_a),
    .i_dq(dq_w), .i_go(go), .i_mode(mode), .i_busy_n(busy), .i_pd7(pd7), .i_array(arr),
    .i_dq_oe(dq_oe), .o_dq(mdq), .o_rb_low(rb_low));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus transfer, held until waitrequest is low at an edge
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    av_a <= a;
    av_d <= d;
    av_wr <= w;
    av_rd <= !w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 100);
    q = rdata;
    if (n >= 100) fails++;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask
  // set the flash up, start an operation, wait for done; f is the first status
  task automatic poll(input logic [2:0] op, input logic [1:0] m, input logic [7:0] b,
                      input logic p, input logic [15:0] v, output logic [31:0] q,
                      output logic [31:0] f);
    int n;
    mode <= m;
    busy <= b;
    pd7 <= p;
    arr <= v;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    av(1'b1, 5'h04, 32'h0001_0a5c, q);
    av(1'b1, 5'h08, {24'h0, p, 7'h11}, q);
    av(1'b1, 5'h00, {29'h0, op}, q);
    av(1'b0, 5'h0c, 32'h0, f);
    q = f;
    n = 0;
    while (q[17:16] !== 2'b10 && n < 400)
    begin
      av(1'b0, 5'h0c, 32'h0, q);
      n++;
    end
  endtask
  task automatic t_regs;
    logic [31:0] q;
    av(1'b0, 5'h00, 32'h0, q);
    chk("ctrl reset", 32'h0, {29'h0, q[2:0]});
    av(1'b0, 5'h0c, 32'h0, q);
    chk("status reset", 32'h0, {29'h0, q[18:16]});
    av(1'b0, 5'h10, 32'h0, q);
    chk("unmapped read", 32'h0, q);
  endtask
  task automatic t_cycles;
    logic [31:0] q, f;
    poll(3'h1, 2'h0, 8'h00, 1'b1, 16'h5a3c, q, f);
    chk("write addr", 32'h0001_0a5c, {14'h0, i_fm.wr_addr});
    chk("write data", 32'h91, {24'h0, i_fm.wr_data[7:0]});
    poll(3'h2, 2'h0, 8'h00, 1'b0, 16'h5a3c, q, f);
    chk("read data", 32'h5a3c, {16'h0, q[15:0]});
  endtask
  task automatic t_prog_dpoll;
    logic [31:0] q, f;
    poll(3'h3, 2'h0, 8'h03, 1'b1, 16'h00a5, q, f);
    chk("busy pin", 32'h0, {31'h0, f[19]});
    chk("status", {11'h0, 5'b01010, 16'h00a5}, {11'h0, q[20:0]});
    chk("read count", 32'd5, i_fm.reads);
    chk("poll addr", 32'h0001_0a5c, {14'h0, i_fm.rd_addr});
  endtask
  task automatic t_erase_dpoll;
    logic [31:0] q, f;
    poll(3'h3, 2'h1, 8'h04, 1'b1, 16'hffff, q, f);
    chk("status", {11'h0, 5'b01010, 16'hffff}, {11'h0, q[20:0]});
    chk("read count", 32'd6, i_fm.reads);
  endtask
  task automatic t_fail_dpoll;
    logic [31:0] q, f;
    poll(3'h3, 2'h2, 8'h02, 1'b0, 16'h0033, q, f);
    chk("fail done", 32'h3, {30'h0, q[18:17]});
    chk("read count", 32'd4, i_fm.reads);
    chk("reset cmd", 32'h1, {31'h0, i_fm.rst_seen});
  endtask
  task automatic t_tpoll;
    logic [31:0] q, f;
    poll(3'h4, 2'h0, 8'h05, 1'b1, 16'h0012, q, f);
    chk("busy pin", 32'h0, {31'h0, f[19]});
    chk("status", {11'h0, 5'b01010, 16'h0012}, {11'h0, q[20:0]});
    poll(3'h4, 2'h3, 8'h00, 1'b1, 16'h0000, q, f);
    chk("suspend", 32'h1a, {27'h0, q[20:16]});
    poll(3'h4, 2'h2, 8'h03, 1'b1, 16'h0000, q, f);
    chk("fail done", 32'h3, {30'h0, q[18:17]});
    chk("reset cmd", 32'h1, {31'h0, i_fm.rst_seen});
  endtask
  // abort a long erase poll, then a fresh toggle poll starts from its first pair
  task automatic t_abort;
    logic [31:0] q, f;
    mode <= 2'h1;
    busy <= 8'hff;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    av(1'b1, 5'h00, 32'h0000_0003, q);
    av(1'b1, 5'h00, 32'h0000_0008, q);
    q = 32'h0;
    repeat (400)
      if (q[17:16] !== 2'b10) av(1'b0, 5'h0c, 32'h0, q);
    chk("abort flags", 32'h2, {29'h0, q[18:16]});
    chk("abort reads", 32'd1, i_fm.reads);
    poll(3'h4, 2'h3, 8'h00, 1'b1, 16'h0000, q, f);
    chk("restart reads", 32'd3, i_fm.reads);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_cycles();
    t_prog_dpoll();
    t_erase_dpoll();
    t_fail_dpoll();
    t_tpoll();
    t_abort();
    close_out();
  end
  // watchdog: the whole run needs well under this
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
